// File: verilog/drc_vol_pkg.sv
// Purpose: shared constants and types of the playback gain path
// Assumes: one sample frame per fs period, volume and dynamics in 0.5 dB codes
// Notes:   ctrl_t field order is the bit layout of the control register
package drc_vol_pkg;

  // register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] VOL_ADDR  = 8'h04;
  localparam logic [7:0] STAT_ADDR = 8'h08;

  // reset values
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [7:0]  VOL_RST  = 8'h0c;

  // gain codes, 0.5 dB per code below +6 dB
  localparam logic [7:0] MUTE_CODE = 8'hc0;
  localparam logic [2:0] LATT_MAX  = 3'h5;

  // timing counts, all in fs periods
  localparam logic [9:0]  SPAN_SLOW = 10'h308;  // 776/fs full span
  localparam logic [9:0]  SPAN_FAST = 10'h0c2;  // 194/fs full span
  localparam logic [11:0] ATT_BASE  = 12'h01e;  // 0.5 dB per 30/fs = 0.8 dB/ms at 48 kHz
  localparam logic [11:0] REC_BASE  = 12'hea6;  // 0.5 dB per 3750/fs = 6.4 dB/s at 48 kHz

  // full scale of a 24-bit sample, at product width
  localparam logic signed [40:0] FULL_SCALE = 41'sh00000800000;

  // linear mantissa of 0 .. -5.5 dB in 0.5 dB steps, Q1.15
  localparam logic [15:0] MANT [12] = '{16'h8000, 16'h78d7, 16'h7215, 16'h6bb3,
                                        16'h65ad, 16'h5ffd, 16'h5a9e, 16'h558c,
                                        16'h50c3, 16'h4c3f, 16'h47fb, 16'h43f4};

  typedef enum logic [1:0] {
    DRC_HOLD = 2'b00,
    DRC_ATT  = 2'b01,
    DRC_REC  = 2'b10
  } drc_mode_t;

  typedef struct packed {
    logic             soft_mute_request;
    logic             vtm;
    logic [1:0]       rspd;
    logic [2:0]       latt;
    logic             cpwr;
    logic             den;
    logic             dpwr;
    logic [1:0]       comp;
  } ctrl_t;

  typedef struct packed {
    logic [1:0][23:0] ch;
  } frame_t;

  typedef struct packed {
    ctrl_t            ctrl;
    logic [7:0]       vol;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [7:0]       curVol;
    logic [9:0]       volAcc;
    logic [7:0]       drcAtt;
    logic [11:0]      drcAcc;
    drc_mode_t        mode;
    logic             outValid;
    frame_t           outData;
    logic             tailValid;
    frame_t           tail;
    logic             inReady;
  } state_t;

endpackage : drc_vol_pkg

// File: verilog/playback_drc_volume_softmute.sv
// Purpose: playback dynamics stage, shared stereo volume and soft mute
// Assumes: apb slave, stereo frames over valid/ready, one frame per fs
// Notes:   gains are 0.5 dB codes; rates count frames, not mclk cycles
`timescale 1ns/1ps
`default_nettype none

module playback_drc_volume_softmute
  import drc_vol_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // sample frames in
  input  wire logic        inValid,
  output var  logic        inReady,
  input  wire frame_t      inFrame,
  // sample frames out
  output var  logic        outValid,
  input  wire logic        outReady,
  output var  frame_t      outFrame
);

  state_t           s;
  state_t           next_s;

  logic             push;
  logic             pop;
  logic             dynOn;
  logic             mapped;
  logic [7:0]       target;
  logic [9:0]       span;
  logic [8:0]       tot;
  logic             muted;
  logic [3:0]       mIdx;
  logic [4:0]       shift;
  wire logic [1:0][23:0] yv;
  wire logic [1:0]  over;
  logic             anyOver;
  logic [31:0]      rdMux;

  assign push    = inValid & s.inReady;
  assign pop     = s.outValid & outReady;
  assign dynOn   = s.ctrl.dpwr & s.ctrl.den;
  assign mapped  = (paddr == CTRL_ADDR) | (paddr == VOL_ADDR) | (paddr == STAT_ADDR);
  assign anyOver = |over;

  // codes above mute count as mute
  assign target = (s.ctrl.soft_mute_request | (s.vol > MUTE_CODE)) ? MUTE_CODE : s.vol;
  assign span   = s.ctrl.vtm ? SPAN_FAST : SPAN_SLOW;

  // volume and dynamics attenuation add in the same 0.5 dB code space
  assign tot   = {1'b0, s.curVol} + {1'b0, s.drcAtt};
  assign muted = tot >= {1'b0, MUTE_CODE};
  assign mIdx  = 4'(tot % 9'h00c);
  assign shift = 5'(tot / 9'h00c) + 5'h0e;

  // one gain for both channels
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_ch
      logic signed [40:0] prod;
      logic signed [40:0] q;
      logic signed [40:0] mag;
      logic signed [40:0] thr;
      logic        [23:0] y;
      assign prod = $signed(inFrame.ch[i]) * $signed({1'b0, MANT[mIdx]});
      assign q    = prod >>> shift;
      assign mag  = q[40] ? -q : q;
      // compression lowers the detection level by 6 dB per step
      assign thr     = FULL_SCALE >>> s.ctrl.comp;
      assign over[i] = ~muted & (mag >= thr);
      always_comb begin
        if (muted) begin
          y = 24'h000000;
        end else if (q >= FULL_SCALE) begin
          y = 24'h7fffff;
        end else if (q < -FULL_SCALE) begin
          y = 24'h800000;
        end else begin
          y = q[23:0];
        end
      end
      assign yv[i] = y;
    end
  endgenerate

  always_comb begin
    case (paddr)
      CTRL_ADDR: rdMux = {20'h00000, s.ctrl};
      VOL_ADDR:  rdMux = {24'h000000, s.vol};
      STAT_ADDR: rdMux = {14'h0000, s.mode, s.drcAtt, s.curVol};
      default:   rdMux = 32'h00000000;
    endcase
  end

  always_comb begin
    drc_mode_t nm;
    nm     = DRC_HOLD;
    next_s = s;

    // apb: answer one cycle after setup, writes land at the access edge
    next_s.pready  = psel & ~penable;
    next_s.pslverr = psel & ~penable & ~mapped;
    if (psel & ~penable) begin
      next_s.prdata = pwrite ? 32'h00000000 : rdMux;
    end
    if (psel & penable & s.pready & pwrite & ~s.pslverr) begin
      if (paddr == CTRL_ADDR) begin
        // the ramps read these live; software keeps them still while running
        next_s.ctrl = ctrl_t'(pwdata[11:0]);
        if (pwdata[7:5] > LATT_MAX) begin
          next_s.ctrl.latt = LATT_MAX;
        end
      end else if (paddr == VOL_ADDR) begin
        next_s.vol = pwdata[7:0];
      end
    end

    // the ramps below advance once per frame taken, never per mclk; the stage-off clear and the buffer act on any mclk
    if (push) begin
      // volume ramp: 192 codes spread evenly over span frames
      if (s.curVol != target) begin
        if (s.volAcc + 10'(MUTE_CODE) >= span) begin
          next_s.volAcc = s.volAcc + 10'(MUTE_CODE) - span;
          next_s.curVol = (s.curVol < target) ? s.curVol + 8'h01
                                              : s.curVol - 8'h01;
        end else begin
          next_s.volAcc = s.volAcc + 10'(MUTE_CODE);
        end
      end else begin
        next_s.volAcc = 10'h000;
      end

      // dynamics stage: unity when compression is off, limiter still live
      if (dynOn & anyOver & (s.drcAtt < MUTE_CODE)) begin
        nm = DRC_ATT;
      end else if (dynOn & (s.drcAtt != 8'h00)) begin
        nm = DRC_REC;
      end
      next_s.mode = nm;
      if (nm != s.mode) begin
        next_s.drcAcc = 12'h000;
      end
      case (nm)
        DRC_ATT: begin
          // fastest code asks for more than a step per frame; capped at one
          if (next_s.drcAcc + (12'h001 << s.ctrl.latt) >= ATT_BASE) begin
            next_s.drcAcc = 12'h000;
            next_s.drcAtt = s.drcAtt + 8'h01;
          end else begin
            next_s.drcAcc = next_s.drcAcc + (12'h001 << s.ctrl.latt);
          end
        end
        DRC_REC: begin
          if (next_s.drcAcc + (12'h001 << s.ctrl.rspd) >= REC_BASE) begin
            next_s.drcAcc = next_s.drcAcc + (12'h001 << s.ctrl.rspd) - REC_BASE;
            next_s.drcAtt = s.drcAtt - 8'h01;
          end else begin
            next_s.drcAcc = next_s.drcAcc + (12'h001 << s.ctrl.rspd);
          end
        end
        default: begin
          next_s.drcAcc = 12'h000;
          if (~dynOn) begin
            next_s.drcAtt = 8'h00;
          end
        end
      endcase
    end else if (~dynOn) begin
      next_s.drcAtt = 8'h00;
      next_s.drcAcc = 12'h000;
      next_s.mode   = DRC_HOLD;
    end

    // two-entry buffer: head drives the outputs, tail absorbs a stall
    if (~s.outValid | pop) begin
      if (s.tailValid) begin
        next_s.outValid  = 1'b1;
        next_s.outData   = s.tail;
        next_s.tailValid = push;
        if (push) begin
          next_s.tail.ch = yv;
        end
      end else begin
        next_s.outValid = push;
        if (push) begin
          next_s.outData.ch = yv;
        end
      end
    end else if (push) begin
      next_s.tail.ch   = yv;
      next_s.tailValid = 1'b1;
    end
    // a switch to the short span mid-ramp restarts a fraction at or past that span, no burst of steps
    if (next_s.volAcc >= (next_s.ctrl.vtm ? SPAN_FAST : SPAN_SLOW)) begin
      next_s.volAcc = 10'h000;
    end
    next_s.inReady = ~next_s.tailValid;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s          <= '0;
      s.ctrl     <= ctrl_t'(CTRL_RST);
      s.vol      <= VOL_RST;
      s.curVol   <= VOL_RST;
      s.mode     <= DRC_HOLD;
    end else begin
      s <= next_s;
    end
  end

  assign prdata   = s.prdata;
  assign pready   = s.pready;
  assign pslverr  = s.pslverr;
  assign inReady  = s.inReady;
  assign outValid = s.outValid;
  assign outFrame = s.outData;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  drc_unity_a:
    assert property (!(s.ctrl.dpwr && s.ctrl.den) |=> s.drcAtt == 8'h00)
    else $error("dynamics gain not unity while stage is off");

  lim_attack_a:
    assert property (push && dynOn && anyOver && s.drcAtt < MUTE_CODE
                     |=> s.mode == DRC_ATT && s.drcAtt >= $past(s.drcAtt))
    else $error("limiter did not attenuate on overload");

  rec_rise_a:
    assert property (s.mode == DRC_REC && $past(s.mode) == DRC_REC
                     |-> s.drcAtt <= $past(s.drcAtt))
    else $error("recovery moved gain the wrong way");

  vol_span_a:
    assert property (s.volAcc < span)
    else $error("volume ramp accumulator beyond span");

  vol_step_a:
    assert property ($changed(s.curVol) |-> $past(push) &&
                     (s.curVol == $past(s.curVol) + 8'h01 ||
                      s.curVol + 8'h01 == $past(s.curVol)))
    else $error("volume moved more than one code or without a frame");

  mute_zero_a:
    assert property (push && muted && !s.outValid |=> outFrame == '0)
    else $error("muted frame not zero");

  ramp_back_a:
    assert property (push && s.curVol < target |=> s.curVol >= $past(s.curVol))
    else $error("ramp moved away from target");

  stall_hold_a:
    assert property (outValid && !outReady |=> outValid && $stable(outFrame))
    else $error("stalled frame lost or changed");

  chan_match_a:
    assert property (push && !s.outValid && inFrame.ch[0] == inFrame.ch[1]
                     |=> outFrame.ch[0] == outFrame.ch[1])
    else $error("left and right gains differ");

endmodule : playback_drc_volume_softmute

`default_nettype wire

// File: testbench/playback_drc_volume_softmute_tb.sv
// Purpose: self-checking bench of the playback gain path
// Assumes: apb answers with pready, frames over valid/ready, one frame per fs
// Notes:   random frames and sink stalls come from one fixed seed
`timescale 1ns/1ps
`default_nettype none
module playback_drc_volume_softmute_tb import drc_vol_pkg::*;;
  logic        mclk, reset_n, psel, penable, pwrite, inValid, outReady, hold, perr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, inReady, outValid;
  frame_t      inFrame, outFrame;
  frame_t      expQ[$];
  frame_t      gotQ[$];
  integer      err_count = 0;
  integer      num_checks = 0;
  integer      seed = 32'hfa8c9637;
  int          n;

  playback_drc_volume_softmute playback_drc_volume_softmute_i (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inValid(inValid), .inReady(inReady), .inFrame(inFrame),
    .outValid(outValid), .outReady(outReady), .outFrame(outFrame));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // random sink stalls keep both buffer entries busy
  always @(posedge mclk) begin
    outReady <= hold ? 1'b0 : 1'($random(seed));
    if (outValid === 1'b1 && outReady === 1'b1) gotQ.push_back(outFrame);
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    num_checks++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic summarize;
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    // one idle edge first, so psel is never assigned twice in one step
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1 && ++k < 50);
    if (k == 50) err_count++;
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // expected sample for total attenuation code t
  function automatic logic [23:0] scale(input logic [23:0] s, input int t);
    logic signed [42:0] p;
    if (t >= 192) return 24'h0;
    p = $signed(s) * $signed({1'b0, (17'(MANT[t % 12]) << 1) >> (t / 12)});
    return 24'(p >>> 15);
  endfunction : scale

  // leaves inValid high so back-to-back frames need no gap
  task automatic send(input int t, input logic big);
    frame_t f;
    int     k;
    k = 0;
    f = big ? {2{24'h7fffff}} : {24'($random(seed)), 24'($random(seed))};
    inFrame <= f;
    inValid <= 1'b1;
    do @(posedge mclk); while (inReady !== 1'b1 && ++k < 50);
    if (k == 50) err_count++;
    expQ.push_back({scale(f.ch[1], t), scale(f.ch[0], t)});
  endtask : send

  task automatic drain;
    int k;
    k = 0;
    inValid <= 1'b0;
    while (gotQ.size() < expQ.size() && k++ < 2000) @(posedge mclk);
    check(48'(gotQ.size()), 48'(expQ.size()));
    foreach (expQ[i]) if (i < gotQ.size()) check(gotQ[i], expQ[i]);
    expQ.delete();
    gotQ.delete();
  endtask : drain

  task automatic burst(input int cnt, input int t);
    repeat (cnt) send(t, 1'b0);
    drain();
  endtask : burst

  // frames until the applied code reaches tgt, checked against a window
  task automatic rampTo(input logic [7:0] tgt, input int lo, input int hi);
    int k;
    k = 0;
    n = 0;
    do begin
      send(0, 1'b0);
      inValid <= 1'b0;
      n++;
      apb(1'b0, STAT_ADDR, 32'h0);
    end while (rd[7:0] !== tgt && n < 400);
    check(48'(n >= lo && n <= hi), 48'h1);
    // let the buffer empty so no stale frame reaches the next drain
    while (outValid !== 1'b0 && k++ < 50) @(posedge mclk);
    expQ.delete();
    gotQ.delete();
  endtask : rampTo

  initial begin
    {psel, penable, pwrite, inValid, hold} = '0;
    paddr = '0;
    pwdata = '0;
    inFrame = '0;
    reset_n = 1'b0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check(48'(rd), 48'(CTRL_RST));
    apb(1'b0, VOL_ADDR, 32'h0);
    check(48'(rd), 48'(VOL_RST));
    apb(1'b0, 8'h0c, 32'h0);
    check(48'(perr), 48'h1);
    apb(1'b1, CTRL_ADDR, 32'h0fff);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check(48'(rd), 48'h0fbf);
    apb(1'b1, CTRL_ADDR, 32'h0);
    burst(16, 12);
    apb(1'b1, VOL_ADDR, 32'h18);
    rampTo(8'h18, 47, 51);
    burst(16, 24);
    apb(1'b1, CTRL_ADDR, 32'h0c00);
    rampTo(MUTE_CODE, 166, 172);
    burst(8, 192);
    apb(1'b1, CTRL_ADDR, 32'h0400);
    rampTo(8'h18, 166, 172);
    apb(1'b1, CTRL_ADDR, 32'h0c00);
    repeat (40) send(0, 1'b0);
    inValid <= 1'b0;
    apb(1'b1, CTRL_ADDR, 32'h0400);
    rampTo(8'h18, 37, 41);
    burst(16, 24);
    hold <= 1'b1;
    send(24, 1'b0);
    send(24, 1'b0);
    inValid <= 1'b0;
    repeat (3) @(posedge mclk);
    check(48'(inReady), 48'h0);
    hold <= 1'b0;
    drain();
    apb(1'b1, VOL_ADDR, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'h04ac);
    repeat (40) send(0, 1'b1);
    inValid <= 1'b0;
    apb(1'b0, STAT_ADDR, 32'h0);
    check(48'(rd[15:8] != 8'h0), 48'h1);
    // disable first, speed fields untouched while the stage runs
    apb(1'b1, CTRL_ADDR, 32'h04a0);
    apb(1'b0, STAT_ADDR, 32'h0);
    check(48'(rd[15:8]), 48'h0);
    apb(1'b1, VOL_ADDR, 32'h0c);
    repeat (20) send(0, 1'b1);
    inValid <= 1'b0;
    apb(1'b1, CTRL_ADDR, 32'h04ac);
    repeat (8) send(0, 1'b1);
    inValid <= 1'b0;
    apb(1'b0, STAT_ADDR, 32'h0);
    check(48'(rd[15:8]), 48'h0);
    apb(1'b1, CTRL_ADDR, 32'h04a0);
    apb(1'b1, CTRL_ADDR, 32'h04a2);
    apb(1'b1, CTRL_ADDR, 32'h04ae);
    repeat (8) send(0, 1'b1);
    inValid <= 1'b0;
    apb(1'b0, STAT_ADDR, 32'h0);
    check(48'(rd[15:8] != 8'h0), 48'h1);
    summarize();
  end

  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule : playback_drc_volume_softmute_tb
`default_nettype wire
